// [design/scm_monitor.sv]
// module: condition monitor, role and pairing logic with register slave
//
// The register addresses and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
module scm_monitor (
  input  wire logic                  i_clk,
  input  wire logic                  i_reset,
  input  wire scm_pkg::scm_avs_type  i_avs,
  input  wire scm_pkg::scm_cond_type i_cond,
  input  wire logic [31:0]           i_own_dist,
  input  wire logic [31:0]           i_sec_dist,
  input  wire logic                  i_meas_valid,
  output logic [31:0]                o_avs_readdata,
  output logic                       o_avs_waitrequest,
  output logic                       o_laser_on,
  output logic                       o_switch_channel_one,
  output logic                       o_switch_channel_two,
  output scm_pkg::scm_pd_type        o_pd
);

  scm_pkg::scm_state_type s_q;
  scm_pkg::scm_state_type s_d;
  scm_pkg::scm_cond_type  cs;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] be_merge(
    input logic [31:0] old,
    input logic [31:0] wd,
    input logic [3:0]  be
  );
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return r;
  endfunction : be_merge

  function automatic logic ge_s(
    input logic [31:0] a,
    input logic [31:0] b
  );
    return $signed(a) >= $signed(b);
  endfunction : ge_s

  // ------------------------------------------------------------
  // pin synchroniser
  // ------------------------------------------------------------
  scm_sync #(
    .W ($bits(scm_pkg::scm_cond_type))
  ) u_sync (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_async (i_cond),
    .o_sync  (cs)
  );

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    logic [7:0]  wa;
    logic [31:0] rv;
    logic [31:0] wd;
    logic [3:0]  be;
    logic [31:0] own;
    logic [31:0] sec;
    logic [31:0] val;
    logic        kill;
    logic        paired;
    wa     = {i_avs.address[7:2], 2'b00};
    rv     = 32'h0000_0000;
    wd     = i_avs.writedata;
    be     = i_avs.byteenable;
    own    = i_own_dist;
    sec    = i_sec_dist;
    val    = 32'h0000_0000;
    kill   = 1'b0;
    paired = 1'b0;
    s_d    = s_q;

    // bus handshake: one wait cycle, then answer
    s_d.wait_b = !((i_avs.read || i_avs.write) && s_q.wait_b);

    if (i_avs.write && !s_q.wait_b) begin
      if (wa == scm_pkg::ADDR_CTRL) begin
        if (be[0]) begin
          if (wd[2:0] <= 3'h4) begin
            s_d.role = scm_pkg::scm_role_type'(wd[2:0]);
          end
          s_d.emit_req = wd[scm_pkg::CTRL_EMIT];
          if (wd[scm_pkg::CTRL_START]) begin
            s_d.ref_st = scm_pkg::REF_WAIT;
          end
        end
      end else if (wa == scm_pkg::ADDR_REFTH) begin
        s_d.ref_thick = be_merge(s_q.ref_thick, wd, be);
      end else if (wa == scm_pkg::ADDR_OFFS) begin
        s_d.offset = be_merge(s_q.offset, wd, be);
      end else if (wa == scm_pkg::ADDR_SDIST) begin
        s_d.sdist = be_merge(s_q.sdist, wd, be);
      end else if (wa == scm_pkg::ADDR_SP1) begin
        s_d.sp1 = be_merge(s_q.sp1, wd, be);
      end else if (wa == scm_pkg::ADDR_SP2) begin
        s_d.sp2 = be_merge(s_q.sp2, wd, be);
      end else if (wa == scm_pkg::ADDR_MSEL) begin
        s_d.msel = 16'(be_merge({16'h0000, s_q.msel}, wd, be));
      end else if (wa == scm_pkg::ADDR_WMASK) begin
        s_d.wmask = 16'(be_merge({16'h0000, s_q.wmask}, wd, be));
      end else if (wa == scm_pkg::ADDR_EMASK) begin
        s_d.emask = 16'(be_merge({16'h0000, s_q.emask}, wd, be));
      end else if (wa == scm_pkg::ADDR_RMIN) begin
        s_d.rmin = be_merge(s_q.rmin, wd, be);
      end else if (wa == scm_pkg::ADDR_RMAX) begin
        s_d.rmax = be_merge(s_q.rmax, wd, be);
      end else if (wa == scm_pkg::ADDR_PSP1) begin
        s_d.psp1 = be_merge(s_q.psp1, wd, be);
      end else if (wa == scm_pkg::ADDR_PSP2) begin
        s_d.psp2 = be_merge(s_q.psp2, wd, be);
      end
    end

    if (wa == scm_pkg::ADDR_CTRL) begin
      rv = {27'h0, 1'b0, s_q.emit_req, s_q.role};
    end else if (wa == scm_pkg::ADDR_REFTH) begin
      rv = s_q.ref_thick;
    end else if (wa == scm_pkg::ADDR_OFFS) begin
      rv = s_q.offset;
    end else if (wa == scm_pkg::ADDR_SDIST) begin
      rv = s_q.sdist;
    end else if (wa == scm_pkg::ADDR_SP1) begin
      rv = s_q.sp1;
    end else if (wa == scm_pkg::ADDR_SP2) begin
      rv = s_q.sp2;
    end else if (wa == scm_pkg::ADDR_MSEL) begin
      rv = {16'h0000, s_q.msel};
    end else if (wa == scm_pkg::ADDR_WMASK) begin
      rv = {16'h0000, s_q.wmask};
    end else if (wa == scm_pkg::ADDR_EMASK) begin
      rv = {16'h0000, s_q.emask};
    end else if (wa == scm_pkg::ADDR_RMIN) begin
      rv = s_q.rmin;
    end else if (wa == scm_pkg::ADDR_RMAX) begin
      rv = s_q.rmax;
    end else if (wa == scm_pkg::ADDR_STAT) begin
      rv = {4'h0, s_q.ref_st == scm_pkg::REF_WAIT, s_q.eff,
            2'b00, s_q.pd, s_q.flags};
    end else if (wa == scm_pkg::ADDR_RESULT) begin
      rv = s_q.result;
    end else if (wa == scm_pkg::ADDR_PSP1) begin
      rv = s_q.psp1;
    end else if (wa == scm_pkg::ADDR_PSP2) begin
      rv = s_q.psp2;
    end
    if (i_avs.read && s_q.wait_b) begin
      s_d.rdata = rv;
    end

    // effective role
    if (s_q.role == scm_pkg::ROLE_AUTOMATIC) begin
      if (cs.adapter) begin
        s_d.eff = cs.main_pos ? scm_pkg::ROLE_MAIN_THICK
                              : scm_pkg::ROLE_SECONDARY;
      end else begin
        s_d.eff = scm_pkg::ROLE_STANDALONE;
      end
    end else begin
      s_d.eff = s_q.role;
    end

    // paired computation
    case (s_q.eff)
      scm_pkg::ROLE_MAIN_THICK: begin
        s_d.result = s_q.sdist - own - sec;
      end
      scm_pkg::ROLE_MAIN_DIFF: begin
        s_d.result = own - sec - s_q.offset;
      end
      default: begin
        s_d.result = own;
      end
    endcase

    // referencing
    case (s_q.ref_st)
      scm_pkg::REF_IDLE: begin
        s_d.ref_st = s_d.ref_st;
      end
      scm_pkg::REF_WAIT: begin
        if (i_meas_valid) begin
          s_d.ref_st = scm_pkg::REF_IDLE;
          if (s_q.eff == scm_pkg::ROLE_MAIN_DIFF) begin
            s_d.offset = own - sec - s_q.ref_thick;
          end else if (s_q.eff == scm_pkg::ROLE_MAIN_THICK) begin
            s_d.sdist = s_q.ref_thick + own + sec;
          end
        end
      end
      default: begin
        s_d.ref_st = scm_pkg::REF_IDLE;
      end
    endcase

    // switching channels
    paired = (s_q.eff == scm_pkg::ROLE_MAIN_THICK) ||
             (s_q.eff == scm_pkg::ROLE_MAIN_DIFF);
    val = s_q.result;
    s_d.sw1 = ge_s(val, paired ? s_q.psp1 : s_q.sp1);
    s_d.sw2 = ge_s(val, paired ? s_q.psp2 : s_q.sp2);

    // laser and status flags
    kill = cs.temp_err || cs.dev_err || cs.laser_err;
    s_d.laser = s_q.emit_req && !kill;
    s_d.flags[scm_pkg::F_UNDERV]  = cs.undervolt;
    s_d.flags[scm_pkg::F_LOWSIG]  = cs.low_signal;
    s_d.flags[scm_pkg::F_AMBIENT] = cs.ambient;
    s_d.flags[scm_pkg::F_OVEREXP] = cs.overexp;
    s_d.flags[scm_pkg::F_TEMPHI]  = cs.temp_high;
    s_d.flags[scm_pkg::F_TEMPLO]  = cs.temp_low;
    s_d.flags[scm_pkg::F_EMITOFF] = !s_d.laser;
    s_d.flags[scm_pkg::F_DIRTY]   = cs.dirty;
    s_d.flags[scm_pkg::F_INTERF]  = cs.interfere;
    s_d.flags[scm_pkg::F_SHORT]   = cs.short_ckt;
    s_d.flags[scm_pkg::F_NOSIG]   = cs.no_signal;
    s_d.flags[scm_pkg::F_CLOSE]   = !cs.no_signal &&
                                    !ge_s(own, s_q.rmin);
    s_d.flags[scm_pkg::F_FAR]     = !cs.no_signal &&
                                    !ge_s(s_q.rmax, own);
    s_d.flags[scm_pkg::F_TEMPERR] = cs.temp_err;
    s_d.flags[scm_pkg::F_DEVERR]  = cs.dev_err;
    s_d.flags[scm_pkg::F_LASERR]  = cs.laser_err;

    // process data bits, re-evaluated each cycle
    s_d.pd.warn = |(s_q.flags & s_q.wmask);
    s_d.pd.err  = |(s_q.flags & s_q.emask);
    for (int i = 0; i < 4; i++) begin
      s_d.pd.msg[i] = s_q.flags[s_q.msel[4*i +: 4]];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      s_q <= scm_pkg::ST_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_avs_readdata       = s_q.rdata;
  assign o_avs_waitrequest    = s_q.wait_b;
  assign o_laser_on           = s_q.laser;
  assign o_switch_channel_one = s_q.sw1;
  assign o_switch_channel_two = s_q.sw2;
  assign o_pd                 = s_q.pd;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  role_auto_a: assert property (
    s_q.role == scm_pkg::ROLE_AUTOMATIC && cs.adapter && cs.main_pos
    |=> s_q.eff == scm_pkg::ROLE_MAIN_THICK)
    else $error("automatic role not thickness at main position");

  thick_calc_a: assert property (
    s_q.eff == scm_pkg::ROLE_MAIN_THICK
    |=> s_q.result == $past(s_q.sdist) - $past(i_own_dist)
                      - $past(i_sec_dist))
    else $error("thickness result wrong");

  diff_calc_a: assert property (
    s_q.eff == scm_pkg::ROLE_MAIN_DIFF
    |=> s_q.result == $past(i_own_dist) - $past(i_sec_dist)
                      - $past(s_q.offset))
    else $error("difference result wrong");

  ref_diff_a: assert property (
    s_q.ref_st == scm_pkg::REF_WAIT && i_meas_valid
    && s_q.eff == scm_pkg::ROLE_MAIN_DIFF
    |=> s_q.offset == $past(i_own_dist) - $past(i_sec_dist)
                      - $past(s_q.ref_thick)
        && s_q.ref_st == scm_pkg::REF_IDLE)
    else $error("alignment offset not stored");

  ref_thick_a: assert property (
    s_q.ref_st == scm_pkg::REF_WAIT && i_meas_valid
    && s_q.eff == scm_pkg::ROLE_MAIN_THICK
    |=> s_q.sdist == $past(s_q.ref_thick) + $past(i_own_dist)
                     + $past(i_sec_dist))
    else $error("sensor distance not stored");

  pair_sw_a: assert property (
    s_q.eff == scm_pkg::ROLE_MAIN_DIFF
    |=> s_q.sw1 == ($signed($past(s_q.result)) >=
                    $signed($past(s_q.psp1))))
    else $error("paired switching point not used");

  msg_slot_a: assert property (
    1'b1 |=> o_pd.msg[2] == $past(s_q.flags[s_q.msel[11:8]]))
    else $error("message slot mismatch");

  warn_or_a: assert property (
    ##1 o_pd.warn == |($past(s_q.flags) & $past(s_q.wmask)))
    else $error("collective warning mismatch");

  err_clear_a: assert property (
    (s_q.flags & s_q.emask) == 16'h0000 [*2] |=> !o_pd.err)
    else $error("collective error stuck");

  emit_flag_a: assert property (
    !o_laser_on |-> s_q.flags[scm_pkg::F_EMITOFF])
    else $error("emitter off without flag");

  laser_kill_a: assert property (
    cs.temp_err || cs.dev_err || cs.laser_err
    |=> !o_laser_on ##0 s_q.flags[15:13] != 3'b000)
    else $error("laser not forced off");

  range_far_a: assert property (
    !cs.no_signal && $signed(i_own_dist) > $signed(s_q.rmax)
    |=> s_q.flags[scm_pkg::F_FAR] && !s_q.flags[scm_pkg::F_NOSIG])
    else $error("too far flag missing");

  bus_wait_a: assert property (
    (i_avs.read || i_avs.write) && o_avs_waitrequest
    |=> !o_avs_waitrequest ##1 o_avs_waitrequest)
    else $error("waitrequest sequence broken");

endmodule : scm_monitor

// [design/scm_pkg.sv]
// package: constants, types and reset state of the condition monitor
package scm_pkg;

  // ------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_REFTH  = 8'h04;
  localparam logic [7:0] ADDR_OFFS   = 8'h08;
  localparam logic [7:0] ADDR_SDIST  = 8'h0C;
  localparam logic [7:0] ADDR_SP1    = 8'h10;
  localparam logic [7:0] ADDR_SP2    = 8'h14;
  localparam logic [7:0] ADDR_MSEL   = 8'h18;
  localparam logic [7:0] ADDR_WMASK  = 8'h1C;
  localparam logic [7:0] ADDR_EMASK  = 8'h20;
  localparam logic [7:0] ADDR_RMIN   = 8'h24;
  localparam logic [7:0] ADDR_RMAX   = 8'h28;
  localparam logic [7:0] ADDR_STAT   = 8'h2C;
  localparam logic [7:0] ADDR_RESULT = 8'h30;
  localparam logic [7:0] ADDR_PSP1   = 8'h34;
  localparam logic [7:0] ADDR_PSP2   = 8'h38;

  // ------------------------------------------------------------
  // control field positions
  // ------------------------------------------------------------
  localparam int CTRL_EMIT  = 3;
  localparam int CTRL_START = 4;

  // ------------------------------------------------------------
  // status message indices
  // ------------------------------------------------------------
  localparam int F_UNDERV = 0;
  localparam int F_LOWSIG = 1;
  localparam int F_AMBIENT = 2;
  localparam int F_OVEREXP = 3;
  localparam int F_TEMPHI = 4;
  localparam int F_TEMPLO = 5;
  localparam int F_EMITOFF = 6;
  localparam int F_DIRTY = 7;
  localparam int F_INTERF = 8;
  localparam int F_SHORT = 9;
  localparam int F_NOSIG = 10;
  localparam int F_CLOSE = 11;
  localparam int F_FAR = 12;
  localparam int F_TEMPERR = 13;
  localparam int F_DEVERR = 14;
  localparam int F_LASERR = 15;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    ROLE_STANDALONE, ROLE_SECONDARY, ROLE_MAIN_THICK,
    ROLE_MAIN_DIFF, ROLE_AUTOMATIC
  } scm_role_type;

  typedef enum logic {REF_IDLE, REF_WAIT} scm_ref_type;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [7:0]  address;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } scm_avs_type;

  typedef struct packed {
    logic undervolt;
    logic low_signal;
    logic ambient;
    logic overexp;
    logic temp_high;
    logic temp_low;
    logic dirty;
    logic interfere;
    logic short_ckt;
    logic no_signal;
    logic temp_err;
    logic dev_err;
    logic laser_err;
    logic adapter;
    logic main_pos;
  } scm_cond_type;

  typedef struct packed {
    logic       warn;
    logic       err;
    logic [3:0] msg;
  } scm_pd_type;

  typedef struct packed {
    scm_role_type role;
    scm_role_type eff;
    scm_ref_type  ref_st;
    logic         emit_req;
    logic [31:0]  ref_thick;
    logic [31:0]  offset;
    logic [31:0]  sdist;
    logic [31:0]  sp1;
    logic [31:0]  sp2;
    logic [31:0]  psp1;
    logic [31:0]  psp2;
    logic [15:0]  msel;
    logic [15:0]  wmask;
    logic [15:0]  emask;
    logic [31:0]  rmin;
    logic [31:0]  rmax;
    logic [15:0]  flags;
    logic [31:0]  result;
    logic         laser;
    logic         sw1;
    logic         sw2;
    scm_pd_type   pd;
    logic [31:0]  rdata;
    logic         wait_b;
  } scm_state_type;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [31:0] RST_OFFSET = 32'h0000_0000;
  localparam logic [31:0] RST_SDIST  = 32'h001E_8480;
  localparam logic [31:0] RST_REFTH  = 32'h0000_0000;
  localparam logic [15:0] RST_MSEL   = 16'h9421;
  localparam logic [15:0] RST_WMASK  = 16'h01B7;
  localparam logic [15:0] RST_EMASK  = 16'h7E00;
  localparam logic [31:0] RST_RMIN   = 32'h8000_0000;
  localparam logic [31:0] RST_RMAX   = 32'h7FFF_FFFF;
  localparam logic [31:0] RST_SP     = 32'h0000_0000;

  localparam scm_state_type ST_RST = '{
    role: ROLE_AUTOMATIC, eff: ROLE_STANDALONE, ref_st: REF_IDLE,
    emit_req: 1'b1, ref_thick: RST_REFTH, offset: RST_OFFSET,
    sdist: RST_SDIST, sp1: RST_SP, sp2: RST_SP, psp1: RST_SP,
    psp2: RST_SP, msel: RST_MSEL, wmask: RST_WMASK,
    emask: RST_EMASK, rmin: RST_RMIN, rmax: RST_RMAX,
    flags: 16'h0040, result: 32'h0000_0000, laser: 1'b0,
    sw1: 1'b0, sw2: 1'b0, pd: 6'h00, rdata: 32'h0000_0000,
    wait_b: 1'b1
  };

endpackage : scm_pkg

// [design/scm_sync.sv]
// module: three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
module scm_sync #(
  parameter int W = 15
) (
  input  wire logic         i_clk,
  input  wire logic         i_reset,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] o;
  } scm_sync_state_type;

  scm_sync_state_type s_q;
  scm_sync_state_type s_d;

  // ------------------------------------------------------------
  // stages; output follows only where stage two and three agree
  // ------------------------------------------------------------
  always_comb begin
    s_d    = s_q;
    s_d.s1 = i_async;
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
    s_d.o  = (s_q.s3 & ~(s_q.s2 ^ s_q.s3)) | (s_q.o & (s_q.s2 ^ s_q.s3));
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_sync = s_q.o;

endmodule : scm_sync

// [dv/scm_sec_model.sv]
// secondary sensor model: presents its distance and a settled flag
`timescale 1ns/100ps
module scm_sec_model (
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  input  wire logic [31:0] i_target,
  output logic      [31:0] o_sec_dist,
  output logic             o_meas_valid
);
  // ------------------------------------------------------------
  // measurement path
  // ------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_sec_dist   <= 32'h0000_0000;
      o_meas_valid <= 1'b0;
    end else begin
      o_sec_dist   <= i_target;
      o_meas_valid <= (i_target == o_sec_dist); // object settled
    end
  end
endmodule : scm_sec_model

// [dv/sensor_condition_monitor_bench.sv]
// testbench: register, condition, role and referencing checks
`timescale 1ns/100ps
module sensor_condition_monitor_bench;
  logic                  i_clk = 1'b0;
  logic                  i_reset = 1'b1;
  scm_pkg::scm_avs_type  avs;
  scm_pkg::scm_cond_type cond;
  logic [31:0]           own;
  logic [31:0]           tgt;
  logic [31:0]           sec;
  logic                  valid;
  logic [31:0]           rd;
  logic [31:0]           readdata;
  logic                  waitreq;
  logic                  laser;
  logic                  sw1;
  logic                  sw2;
  scm_pkg::scm_pd_type   pd;
  int                    fails = 0;
  int                    n_compared = 0;
  logic [7:0]  ra [7] = '{8'h00, 8'h08, 8'h0C, 8'h04, 8'h18, 8'h1C, 8'h20};
  logic [31:0] rv [7] = '{32'hC, 32'h0, 32'h001E_8480, 32'h0, 32'h9421,
                          32'h01B7, 32'h7E00};
  logic [14:0] cv [13] = '{15'h4000, 15'h2000, 15'h1000, 15'h0800,
    15'h0400, 15'h0200, 15'h0100, 15'h0080, 15'h0040, 15'h0020,
    15'h0010, 15'h0008, 15'h0004};
  int          fi [13] = '{0, 1, 2, 3, 4, 5, 7, 8, 9, 10, 13, 14, 15};
  logic [5:0]  pe [13] = '{6'h20, 6'h21, 6'h22, 6'h00, 6'h24, 6'h20,
    6'h20, 6'h20, 6'h18, 6'h10, 6'h10, 6'h10, 6'h00};
  logic [12:0] le = 13'h03FF;
  logic [31:0] re [4] = '{32'h64, 32'h64, 32'h001E_83EA, 32'h32};
  logic [14:0] ad [3] = '{15'h0003, 15'h0002, 15'h0000};

  always #10 i_clk = ~i_clk;

  scm_monitor i_dut (
    .i_clk                (i_clk),
    .i_reset              (i_reset),
    .i_avs                (avs),
    .i_cond               (cond),
    .i_own_dist           (own),
    .i_sec_dist           (sec),
    .i_meas_valid         (valid),
    .o_avs_readdata       (readdata),
    .o_avs_waitrequest    (waitreq),
    .o_laser_on           (laser),
    .o_switch_channel_one (sw1),
    .o_switch_channel_two (sw2),
    .o_pd                 (pd)
  );

  scm_sec_model i_sec (
    .i_clk        (i_clk),
    .i_reset      (i_reset),
    .i_target     (tgt),
    .o_sec_dist   (sec),
    .o_meas_valid (valid)
  );

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task results;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : results

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      fails++;
    end
  endtask : chk

  task xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge i_clk);
    avs <= '{read: !wr, write: wr, address: a, writedata: d,
             byteenable: 4'hF};
    do begin
      @(posedge i_clk);
      k++;
    end while (waitreq !== 1'b0 && k < 50);
    if (waitreq !== 1'b0) begin
      fails++;
      results();
    end
    rd = readdata;
    avs <= '0;
  endtask : xfer

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    avs  <= '0;
    cond <= '0;
    own  <= 32'h0000_0064;
    tgt  <= 32'h0000_0032;
    repeat (6) @(posedge i_clk);
    i_reset <= 1'b0;
    @(posedge i_clk);
    for (int i = 0; i < 7; i++) begin
      xfer(1'b0, ra[i], 32'h0);
      chk("reset value", rv[i], rd);
    end
    for (int i = 0; i < 13; i++) begin
      cond <= scm_pkg::scm_cond_type'(cv[i]);
      repeat (8) @(posedge i_clk);
      chk("pd", 32'(pe[i]), {26'h0, pd});
      chk("laser", {31'h0, le[i]}, {31'h0, laser});
      xfer(1'b0, 8'h2C, 32'h0);
      chk("flag", 32'h1, {31'h0, rd[fi[i]]});
      chk("emit off", {31'h0, !le[i]}, {31'h0, rd[6]});
      chk("status pd", {26'h0, pe[i]}, {26'h0, rd[21:16]});
      cond <= '0;
      repeat (8) @(posedge i_clk);
      chk("pd clear", 32'h0, {26'h0, pd});
    end
    for (int r = 0; r < 4; r++) begin
      xfer(1'b1, 8'h00, 32'h8 | r);
      repeat (4) @(posedge i_clk);
      xfer(1'b0, 8'h30, 32'h0);
      chk("result", re[r], rd);
    end
    xfer(1'b1, 8'h00, 32'hD);
    xfer(1'b0, 8'h00, 32'h0);
    chk("role", 32'hB, rd);
    xfer(1'b1, 8'h00, 32'h3);
    repeat (4) @(posedge i_clk);
    chk("laser off", 32'h0, {31'h0, laser});
    xfer(1'b0, 8'h2C, 32'h0);
    chk("emit flag", 32'h1, {31'h0, rd[6]});
    xfer(1'b1, 8'h04, 32'h3E8);
    xfer(1'b1, 8'h00, 32'h1B);
    repeat (3) @(posedge i_clk);
    xfer(1'b0, 8'h08, 32'h0);
    chk("offset", 32'hFFFF_FC4A, rd);
    xfer(1'b0, 8'h30, 32'h0);
    chk("diff result", 32'h3E8, rd);
    xfer(1'b1, 8'h00, 32'hA);
    xfer(1'b1, 8'h00, 32'h1A);
    repeat (3) @(posedge i_clk);
    xfer(1'b0, 8'h0C, 32'h0);
    chk("distance", 32'h47E, rd);
    xfer(1'b1, 8'h34, 32'h3E8);
    xfer(1'b1, 8'h38, 32'h3E9);
    repeat (4) @(posedge i_clk);
    chk("switch one", 32'h1, {31'h0, sw1});
    chk("switch two", 32'h0, {31'h0, sw2});
    xfer(1'b0, 8'h30, 32'h0);
    chk("thick result", 32'h3E8, rd);
    xfer(1'b1, 8'h00, 32'hC);
    for (int i = 0; i < 3; i++) begin
      cond <= scm_pkg::scm_cond_type'(ad[i]);
      repeat (8) @(posedge i_clk);
      xfer(1'b0, 8'h2C, 32'h0);
      chk("auto role", 32'h2 >> i, {29'h0, rd[26:24]});
    end
    xfer(1'b1, 8'h00, 32'h8);
    xfer(1'b1, 8'h24, 32'hC8);
    repeat (6) @(posedge i_clk);
    xfer(1'b0, 8'h2C, 32'h0);
    chk("too close", 32'h1, {30'h0, rd[12:11]});
    xfer(1'b1, 8'h24, 32'h8000_0000);
    xfer(1'b1, 8'h28, 32'h32);
    repeat (6) @(posedge i_clk);
    xfer(1'b0, 8'h2C, 32'h0);
    chk("too far", 32'h2, {30'h0, rd[12:11]});
    xfer(1'b0, 8'h3C, 32'h0);
    chk("unmapped", 32'h0, rd);
    results();
  end
endmodule : sensor_condition_monitor_bench
